// ---- hdl/pbs_defs.vh ----
/*
 * Constants of the pipelined burst SRAM port: widths, burst modes, FIFO shape.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef PBS_DEFS_VH
`define PBS_DEFS_VH

`define PBS_ADDR_W      12
`define PBS_DATA_W      32
`define PBS_LANES       4
`define PBS_PAR_W       4
`define PBS_WORD_W      36
`define PBS_MEM_DEPTH   4096
`define PBS_FIFO_DEPTH  8
`define PBS_FIFO_AW     3
`define PBS_BURST_W     2
`define PBS_MODE_LINEAR 1'b0
`define PBS_MODE_INTLV  1'b1
`define PBS_SLEEP_CYC   2'd2

`endif

// ---- hdl/pbs_sram_port.v ----
/*
 * Pipelined burst SRAM port: input registers, burst counter, pipelined
 * read, late write, pipelined deselect, output enables, sleep, and an
 * 8-word read-data FIFO toward a user-side drain.
 * Assumes a controller synchronous to clk_in; bidirectional lines are
 * split into in/out/enable and resolved outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defs.vh"

// ---------------------------------------------------------------
// Read-data FIFO
// ---------------------------------------------------------------
module pbs_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_in,
    input  wire             rst_n_in,
    input  wire [WIDTH-1:0] wr_data_in,
    input  wire             wr_valid_in,
    output wire             wr_ready_out,
    output wire [WIDTH-1:0] rd_data_out,
    output wire             rd_valid_out,
    input  wire             rd_ready_in
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW:0]      wp_r;
    reg [AW:0]      rp_r;
    // Extra pointer bit tells full from empty when the indices meet
    wire            full_w  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire            empty_w = (wp_r == rp_r);
    wire            push_w  = wr_valid_in && !full_w;
    wire            pop_w   = rd_ready_in && !empty_w;

    assign wr_ready_out = !full_w;
    assign rd_valid_out = !empty_w;
    assign rd_data_out  = mem_r[rp_r[AW-1:0]];

    always @(posedge clk_in) begin
        if (push_w) begin
            mem_r[wp_r[AW-1:0]] <= wr_data_in;
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_r <= {(AW+1){1'b0}};
            rp_r <= {(AW+1){1'b0}};
        end else begin
            if (push_w) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop_w) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule // pbs_fifo

// ---------------------------------------------------------------
// SRAM port
// ---------------------------------------------------------------
// What this block does and what it expects of its controller
// R01 - Register every synchronous input on the rising clock edge.
// R02 - Clock gate high: the edge is ignored and pipeline state holds; sleep and read FIFO still run.
// R03 - Read data leaves through output registers clocked on rising edge.
// R04 - Read starts: gate low, all selects active, write strobe high, load.
// R05 - Read data driven after the next edge when drive enable is low.
// R06 - Controller holds drive enable low in the read data cycle.
// R07 - A new command may follow a read immediately, no wait states.
// R08 - Deselect is pipelined; outputs float only after the following edge.
// R09 - Controller must load a new address after a deselect.
// R10 - Burst counter gives up to four accesses from one address.
// R11 - Burst order strap low means linear, high means interleaved.
// R12 - Burst counter walks only the two low address bits and wraps.
// R13 - Advance high advances counter, ignoring selects and write strobe.
// R14 - Read or write direction is kept for every beat of a burst.
// R15 - Write starts: gate low, all selects active, write strobe low.
// R16 - Cycle after a write command, data lines float regardless of enable.
// R17 - Cycle after a write, the next command address is also accepted.
// R18 - Write data captured at the second edge after the command.
// R19 - Only selected byte lanes are written; others stay unchanged.
// R20 - Controller must not drive data while device outputs are active.
// R21 - Drive enable high floats the outputs at the next clock edge, not at once.
// R22 - Sleep high enters low power keeping contents; low in normal use.
// R23 - Outputs float while deselected and the first clock after leaving.
// R24 - Clock gate high does not deselect the device.
// R25 - Unconnected burst order strap reads high: interleaved.
// R26 - Power-up state is deselected with all data lines floating.
module pbs_sram_port (
    input  wire                     clk_in,
    input  wire                     rst_n_in,
    input  wire                     clock_gate_n_in,
    input  wire                     chip_select_first_n_in,
    input  wire                     chip_select_second_in,
    input  wire                     chip_select_third_n_in,
    input  wire                     write_strobe_n_in,
    input  wire                     advance_or_load_in,
    input  wire [`PBS_LANES-1:0]    byte_lane_select_n_in,
    input  wire [`PBS_ADDR_W-1:0]   addr_in,
    input  wire                     output_drive_n_in,
    input  wire                     burst_order_in,
    input  wire                     sleep_request_in,
    input  wire [`PBS_DATA_W-1:0]   data_in,
    input  wire [`PBS_PAR_W-1:0]    parity_lines_in,
    output reg  [`PBS_DATA_W-1:0]   data_out,
    output reg  [`PBS_PAR_W-1:0]    parity_lines_out,
    output reg                      data_oe_out,
    output reg                      sleep_active_out,
    output reg  [`PBS_WORD_W-1:0]   rd_word_out,
    output reg                      rd_valid_out,
    input  wire                     rd_ready_in,
    output reg                      rd_overflow_out
);
    reg [`PBS_WORD_W-1:0] mem_r [0:`PBS_MEM_DEPTH-1];

    // Stage 1: command in flight; stage 2: data cycle
    reg                    s1_act_r;
    reg                    s1_wr_r;
    reg [`PBS_ADDR_W-1:0]  s1_addr_r;
    reg [`PBS_LANES-1:0]   s1_be_n_r;
    reg                    s2_rd_r;
    reg                    s2_wr_r;
    reg [`PBS_ADDR_W-1:0]  s2_addr_r;
    reg [`PBS_LANES-1:0]   s2_be_n_r;
    // Burst base and direction stay latched across advance beats
    reg                    burst_wr_r;
    reg [`PBS_ADDR_W-1:0]  base_r;
    reg [1:0]              cnt_r;
    reg                    desel_r;
    reg                    drive_r;
    reg [`PBS_DATA_W-1:0]  q_data_r;
    reg [`PBS_PAR_W-1:0]   q_par_r;
    reg [1:0]              sleep_cnt_r;
    reg                    sleep_r;
    reg                    out_wait_r;

    wire take_w = !clock_gate_n_in && !sleep_r;                             // see R02, R24
    wire sel_w  = !chip_select_first_n_in && chip_select_second_in && !chip_select_third_n_in;
    wire [1:0] cnt_nxt = cnt_r + 2'b01;
    // Unconnected strap is resolved high by the pad pull-up outside
    wire [1:0] low_nxt = (burst_order_in == `PBS_MODE_LINEAR) ?
                         (base_r[1:0] + cnt_nxt) : (base_r[1:0] ^ cnt_nxt); // see R11, R12, R25

    wire [`PBS_WORD_W-1:0] fifo_word_w;
    wire                   fifo_valid_w;
    wire                   fifo_ready_w;
    // Read beat copied to the FIFO one taken edge after it reached the pins
    wire                   push_w = take_w && s2_rd_r;
    wire                   pop_w  = !out_wait_r || rd_ready_in;
    wire [`PBS_WORD_W-1:0] rd_mem_w = mem_r[s2_addr_r];

    integer i;

    // No forwarding: a read right behind a write to that word shows the old word on the pins, the new one in the FIFO
    // Byte-masked late write
    always @(posedge clk_in) begin
        if (take_w && s2_wr_r) begin
            for (i = 0; i < `PBS_LANES; i = i + 1) begin
                if (!s2_be_n_r[i]) begin                                  // see R19
                    mem_r[s2_addr_r][i*8 +: 8] <= data_in[i*8 +: 8];      // see R18
                    mem_r[s2_addr_r][`PBS_DATA_W+i] <= parity_lines_in[i];
                end
            end
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_act_r   <= 1'b0;
            s1_wr_r    <= 1'b0;
            s1_addr_r  <= {`PBS_ADDR_W{1'b0}};
            s1_be_n_r  <= {`PBS_LANES{1'b1}};
            s2_rd_r    <= 1'b0;
            s2_wr_r    <= 1'b0;
            s2_addr_r  <= {`PBS_ADDR_W{1'b0}};
            s2_be_n_r  <= {`PBS_LANES{1'b1}};
            burst_wr_r <= 1'b0;
            base_r     <= {`PBS_ADDR_W{1'b0}};
            cnt_r      <= 2'b00;
            desel_r    <= 1'b1;                                           // see R26
            drive_r    <= 1'b0;
            q_data_r   <= {`PBS_DATA_W{1'b0}};
            q_par_r    <= {`PBS_PAR_W{1'b0}};
        end else if (take_w) begin                                        // see R01
            if (advance_or_load_in) begin                                 // see R13
                // Continue: selects and write strobe ignored
                cnt_r     <= cnt_nxt;                                     // see R10
                s1_addr_r <= {base_r[`PBS_ADDR_W-1:2], low_nxt};
                s1_wr_r   <= burst_wr_r;                                  // see R14
                s1_be_n_r <= byte_lane_select_n_in;
            end else begin
                s1_act_r   <= sel_w;                                      // see R04, R15
                s1_wr_r    <= !write_strobe_n_in;
                burst_wr_r <= !write_strobe_n_in;
                s1_addr_r  <= addr_in;                                    // see R17
                base_r     <= addr_in;
                s1_be_n_r  <= byte_lane_select_n_in;
                cnt_r      <= 2'b00;
            end
            s2_rd_r   <= s1_act_r && !s1_wr_r;                            // see R07
            s2_wr_r   <= s1_act_r && s1_wr_r;
            s2_addr_r <= s1_addr_r;
            s2_be_n_r <= s1_be_n_r;
            // Deselect reaches the pins one edge late
            desel_r   <= !s1_act_r;                                       // see R08, R23
            drive_r   <= s1_act_r && !s1_wr_r;                            // see R16
            if (s1_act_r && !s1_wr_r) begin
                q_data_r <= mem_r[s1_addr_r][`PBS_DATA_W-1:0];            // see R03, R05
                q_par_r  <= mem_r[s1_addr_r][`PBS_WORD_W-1:`PBS_DATA_W];
            end
        end
    end

    // ---------------------------------------------------------------
    // Pin drivers
    // ---------------------------------------------------------------
    // Drive enable is sampled each clock; a truly async float belongs to the pad
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_out         <= {`PBS_DATA_W{1'b0}};
            parity_lines_out <= {`PBS_PAR_W{1'b0}};
            data_oe_out      <= 1'b0;
        end else begin
            // Stalled or sleeping edges hold the data and parity lines; the drive enable still updates
            if (take_w) begin                                             // see R02
                data_out         <= s1_act_r ? mem_r[s1_addr_r][`PBS_DATA_W-1:0] : q_data_r;
                parity_lines_out <= s1_act_r ? mem_r[s1_addr_r][`PBS_WORD_W-1:`PBS_DATA_W]
                                             : q_par_r;
            end
            // Sleep keeps the lines floating until the port has fully woken
            data_oe_out      <= (take_w ? (s1_act_r && !s1_wr_r) : (drive_r && !desel_r))
                                && !output_drive_n_in && !sleep_request_in
                                && !sleep_r;                              // see R21, R22
        end
    end

    // ---------------------------------------------------------------
    // Sleep
    // ---------------------------------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sleep_cnt_r      <= 2'b00;
            sleep_r          <= 1'b0;
            sleep_active_out <= 1'b0;
        end else begin
            // Request must stand two cycles; a shorter pulse restarts the count
            if (sleep_request_in != sleep_r) begin                        // see R22
                if (sleep_cnt_r == (`PBS_SLEEP_CYC - 2'd1)) begin
                    sleep_r     <= sleep_request_in;
                    sleep_cnt_r <= 2'b00;
                end else begin
                    sleep_cnt_r <= sleep_cnt_r + 2'b01;
                end
            end else begin
                sleep_cnt_r <= 2'b00;
            end
            sleep_active_out <= sleep_r;
        end
    end

    // ---------------------------------------------------------------
    // User-side read stream
    // ---------------------------------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_word_out     <= {`PBS_WORD_W{1'b0}};
            rd_valid_out    <= 1'b0;
            out_wait_r      <= 1'b0;
            rd_overflow_out <= 1'b0;
        end else begin
            // Skid register: FIFO pops only when the output word is free or taken
            if (pop_w) begin
                rd_word_out  <= fifo_word_w;
                rd_valid_out <= fifo_valid_w;
                out_wait_r   <= fifo_valid_w;
            end
            // Port cannot stall the controller, so a full FIFO is flagged
            if (push_w && !fifo_ready_w) begin
                rd_overflow_out <= 1'b1;
            end
        end
    end

    pbs_fifo #(
        .WIDTH (`PBS_WORD_W),
        .DEPTH (`PBS_FIFO_DEPTH),
        .AW    (`PBS_FIFO_AW)
    ) u_fifo (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .wr_data_in   (rd_mem_w),
        .wr_valid_in  (push_w),
        .wr_ready_out (fifo_ready_w),
        .rd_data_out  (fifo_word_w),
        .rd_valid_out (fifo_valid_w),
        .rd_ready_in  (pop_w)
    );
endmodule // pbs_sram_port
`default_nettype wire

// ---- testbench/pbs_sram_port_monitor.sv ----
/* Checker for pbs_sram_port: output drive timing, stalls, sleep.
   Assumes binding to the port's top module, names as on its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defs.vh"
module pbs_sram_port_monitor (
    input wire                   clk_in,
    input wire                   rst_n_in,
    input wire                   clock_gate_n_in,
    input wire                   chip_select_first_n_in,
    input wire                   chip_select_second_in,
    input wire                   chip_select_third_n_in,
    input wire                   write_strobe_n_in,
    input wire                   advance_or_load_in,
    input wire                   output_drive_n_in,
    input wire                   sleep_request_in,
    input wire [`PBS_DATA_W-1:0] data_out,
    input wire                   data_oe_out,
    input wire                   sleep_active_out
);
    // ----
    // Edges the port acts on
    // ----
    wire go  = !clock_gate_n_in && !sleep_active_out && !sleep_request_in;
    wire sel = !chip_select_first_n_in && chip_select_second_in && !chip_select_third_n_in;
    wire ld  = go && !advance_or_load_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_POWERUP_FLOAT: assert property ($rose(rst_n_in) |-> !data_oe_out)
        else $error("drive on after reset");
    AST_STALL_HOLD: assert property (clock_gate_n_in && $stable(output_drive_n_in)
        && $stable(sleep_request_in) && !sleep_active_out
        |=> $stable(data_out) && $stable(data_oe_out))
        else $error("stalled edge changed outputs");
    AST_READ_DRIVE: assert property (ld && sel && write_strobe_n_in ##1 go && !output_drive_n_in |=> data_oe_out)
        else $error("read data not driven");
    AST_WRITE_FLOAT: assert property (ld && sel && !write_strobe_n_in ##1 go |=> !data_oe_out)
        else $error("drive on in write data cycle");
    AST_DESEL_FLOAT: assert property (ld && !sel ##1 go |=> !data_oe_out)
        else $error("drive on after deselect");
    AST_DRIVE_CAUSE: assert property (data_oe_out && !$past(clock_gate_n_in) |-> !$past(output_drive_n_in))
        else $error("drive on with enable high");
    AST_SLEEP_IN: assert property (sleep_request_in [*3] |=> sleep_active_out)
        else $error("sleep not entered");
    AST_SLEEP_OUT: assert property (!sleep_request_in [*3] |=> !sleep_active_out)
        else $error("sleep not left");
    AST_SLEEP_FLOAT: assert property (sleep_active_out |-> !data_oe_out)
        else $error("drive on in sleep");
    cover property (ld && sel && write_strobe_n_in ##2 data_oe_out);
    cover property (clock_gate_n_in [*2]);
    cover property (sleep_active_out);
endmodule // pbs_sram_port_monitor
bind pbs_sram_port pbs_sram_port_monitor i_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .clock_gate_n_in(clock_gate_n_in), .chip_select_first_n_in(chip_select_first_n_in),
    .chip_select_second_in(chip_select_second_in),
    .chip_select_third_n_in(chip_select_third_n_in), .write_strobe_n_in(write_strobe_n_in),
    .advance_or_load_in(advance_or_load_in), .output_drive_n_in(output_drive_n_in),
    .sleep_request_in(sleep_request_in), .data_out(data_out), .data_oe_out(data_oe_out),
    .sleep_active_out(sleep_active_out));
`default_nettype wire

// ---- testbench/pbs_ctl_model.sv ----
/* Controller model: issues port commands, lays write data two taken
   edges after each write beat. Assumes clk_in from the bench. */
`timescale 1ns/1ps
`default_nettype none
module pbs_ctl_model (
    input  wire         clk_in,
    output logic        gate_n_out,
    output logic [2:0]  cs_out,
    output logic        we_n_out,
    output logic        adv_out,
    output logic [3:0]  lane_n_out,
    output logic [11:0] addr_out,
    output logic [35:0] wdata_out
);
    logic        wr_dir_r, v1_r, v2_r;
    logic [35:0] d1_r, d2_r, cur_d, junk_r;
    wire cur_w = adv_out ? wr_dir_r : (cs_out == 3'b010) && !we_n_out;
    initial begin
        {gate_n_out, adv_out, we_n_out, cs_out, lane_n_out} = 10'h0cf;
        {addr_out, cur_d, junk_r, v1_r, v2_r, wr_dir_r} = 87'h0;
    end
    // ----
    // Write data follows its beat by two taken edges
    // ----
    always @(posedge clk_in) begin
        junk_r <= junk_r + 36'h111111111;
        if (!gate_n_out) begin
            if (!adv_out) wr_dir_r <= cur_w;
            {v2_r, d2_r} <= {v1_r, d1_r};
            {v1_r, d1_r} <= {cur_w, cur_d};
        end
    end
    // Released lines show a moving pattern, never stale data
    assign wdata_out = v2_r ? d2_r : junk_r;
    task automatic beat(input logic ld, we_n, input logic [2:0] cs,
                        input logic [11:0] a, input logic [3:0] ln, input logic [35:0] d);
        @(posedge clk_in);
        #1;
        {gate_n_out, adv_out, we_n_out, cs_out} = {1'b0, !ld, we_n, cs};
        {addr_out, lane_n_out, cur_d} = {a, ln, d};
    endtask
    task automatic stall();
        @(posedge clk_in);
        #1;
        gate_n_out = 1'b1;
    endtask
endmodule // pbs_ctl_model
`default_nettype wire

// ---- testbench/pbs_sram_port_tb.sv ----
/* Bench for pbs_sram_port: bursts in both orders, byte lanes, stalls,
   sleep and read FIFO fill. Assumes the model and checker compile first. */
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_port_tb;
    logic        clk_in = 0, rst_n_in = 0, odrv_n = 0, mode = 0, sleep = 0;
    logic        rdy = 1, park = 0, lax = 0, pin_new = 0, gate_n, we_n, adv, oe, slp, rv, ovf;
    logic [2:0]  cs;
    logic [3:0]  ln, p_o;
    logic [11:0] a, b;
    logic [31:0] d_o, r;
    logic [35:0] wd, rw, mem [0:4095];
    logic [35:0] exp_q[$], exp_d[$];
    integer      err_total = 0, total_checks = 0, seed = 32'h42f9;
    always #10 clk_in = ~clk_in;
    pbs_ctl_model i_ctl (.clk_in(clk_in), .gate_n_out(gate_n), .cs_out(cs), .we_n_out(we_n),
        .adv_out(adv), .lane_n_out(ln), .addr_out(a), .wdata_out(wd));
    pbs_sram_port i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .clock_gate_n_in(gate_n),
        .chip_select_first_n_in(cs[2]), .chip_select_second_in(cs[1]),
        .chip_select_third_n_in(cs[0]), .write_strobe_n_in(we_n), .advance_or_load_in(adv),
        .byte_lane_select_n_in(ln), .addr_in(a), .output_drive_n_in(odrv_n),
        .burst_order_in(mode), .sleep_request_in(sleep), .data_in(wd[31:0]),
        .parity_lines_in(wd[35:32]), .data_out(d_o), .parity_lines_out(p_o),
        .data_oe_out(oe), .sleep_active_out(slp), .rd_word_out(rw), .rd_valid_out(rv),
        .rd_ready_in(rdy), .rd_overflow_out(ovf));
    task chk(input logic [35:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----
    // Burst of n beats: writes update the copy, reads queue it
    // ----
    task automatic burst(input logic wr, full, input logic [11:0] base, input int n);
        logic [11:0] ad;
        logic [35:0] d;
        for (int i = 0; i < n; i++) begin
            ad = {base[11:2], mode ? base[1:0] ^ i[1:0] : base[1:0] + i[1:0]};
            d = {r, $random(seed), $random(seed)};
            if (full) d[11:8] = 4'h0;
            odrv_n = wr && i > 1 ? d[12] : 1'b0;
            if (wr) begin
                for (int k = 0; k < 4; k++) if (!d[8+k]) begin
                    mem[ad][8*k+:8] = d[8*k+:8];
                    mem[ad][32+k] = d[32+k];
                end
            end else begin
                exp_d.push_back(mem[ad]);
                if (!lax) exp_q.push_back(mem[ad]);
            end
            if (i == 2 && mode) repeat (2) i_ctl.stall();
            i_ctl.beat(i == 0, i == 0 ? !wr : d[0], i == 0 ? 3'b010 : d[6:4], ad, d[11:8], d);
        end
    endtask
    task idle(input int n);
        repeat (n) i_ctl.beat(1'b1, 1'b1, 3'b100, 12'h0, 4'hf, 36'h0);
    endtask
    always @(posedge clk_in) #1 rdy = !park && $random(seed) > 0;
    // Beat taken at the coming edge: both sides settled at the falling edge
    always @(negedge clk_in) if (rv === 1'b1 && rdy) begin
        if (exp_q.size() > 0) chk(rw, exp_q.pop_front());
        else if (!lax) begin
            err_total++;
            $display("BAD %0t unexpected read beat", $time);
        end
    end
    // Pins looked at half a cycle after a taken edge launched them
    always @(posedge clk_in) pin_new <= !gate_n;
    always @(negedge clk_in) if (pin_new && oe === 1'b1) begin
        if (exp_d.size() > 0) chk({p_o, d_o}, exp_d.pop_front());
        else chk(oe, 1'b0);
    end
    initial begin
        #400000;
        err_total++;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge clk_in);
        #1 rst_n_in = 1;
        chk(oe, 1'b0);
        for (int m = 0; m < 2; m++) begin
            mode = m[0];
            r = $random(seed);
            b = r[11:0] & 12'hffc;
            burst(1, 1, b, 4);
            burst(1, 0, b | 12'h1, 4);
            idle(2);
            burst(0, 0, b | 12'h2, 4);
            burst(1, 1, b ^ 12'h4, 4);
            idle(2);
            burst(0, 0, b ^ 12'h7, 4);
            idle(2);
        end
        sleep = 1;
        idle(4);
        chk(slp, 1'b1);
        sleep = 0;
        idle(4);
        chk(slp, 1'b0);
        burst(0, 0, b, 4);
        idle(20);
        chk(ovf, 1'b0);
        park = 1;
        burst(0, 0, b, 4);
        burst(0, 0, b | 12'h3, 4);
        lax = 1;
        burst(0, 0, b, 4);
        idle(4);
        chk(ovf, 1'b1);
        park = 0;
        for (int w = 0; w < 200 && exp_q.size() > 0; w++) @(posedge clk_in);
        idle(20);
        chk(exp_q.size(), 36'h0);
        chk(exp_d.size(), 36'h0);
        finish_test;
    end
endmodule // pbs_sram_port_tb
`default_nettype wire
